// ### logic/ibc_ctrl.sv
// two-wire bus master/slave controller with control, status and data registers
`timescale 1ns/1ps
`default_nettype none
module ibc_ctrl #(
    parameter logic [15:0] HALF_CYCLES = 16'(ibc_pkg::SCL_HALF_CYCLES)
) (
    input  wire logic        core_clk,        // module clock
    input  wire logic        rst_b,           // async reset, active low
    input  wire logic [4:0]  avs_address,     // byte address
    input  wire logic        avs_read,        // read request
    input  wire logic        avs_write,       // write request
    input  wire logic [31:0] avs_writedata,   // write data
    input  wire logic [3:0]  avs_byteenable,  // byte lanes
    output logic      [31:0] avs_readdata,    // read data
    output logic             avs_waitrequest, // stall
    input  wire logic        scl_i,           // bus clock line level
    output logic             scl_o,           // bus clock drive value
    output logic             scl_oe,          // pull bus clock low
    input  wire logic        sda_i,           // bus data line level
    output logic             sda_o,           // bus data drive value
    output logic             sda_oe,          // pull bus data low
    output logic             irq              // interrupt request
);
    typedef struct packed {
        logic waitreq; logic [7:0] rdata;
        logic ctl_en; logic ctl_ie; logic msel; logic tx; logic ack_drive_value;
        logic [6:0] own_addr; logic gce;
        logic byte_done; logic addressed; logic busy; logic arbitration_lost_flag;
        logic slave_direction_flag; logic pend; logic received_ack_flag;
        logic [7:0] rx_data; logic [7:0] shift; logic [3:0] bit_cnt;
        logic slv_addr; ibc_pkg::ibc_state_e state; logic [1:0] step;
        logic [15:0] timer; logic scl_drv; logic sda_drv; logic irq;
        logic scl_m; logic scl_s; logic scl_p; logic sda_m; logic sda_s; logic sda_p;
    } ibc_regs_s;

    ibc_regs_s s;
    ibc_regs_s next_s;

    logic       acc_wr;
    logic       acc_rd;
    logic       wr_ctl;
    logic       wr_dat;
    logic       rd_dat;
    logic       start_det;
    logic       stop_det;
    logic       rise;
    logic       fall;
    logic       tdone;
    logic       eng_tx;
    logic [7:0] wd;

    assign acc_wr    = avs_write && !s.waitreq && avs_byteenable[0];
    assign acc_rd    = avs_read && !s.waitreq;
    assign wd        = avs_writedata[7:0];
    assign wr_ctl    = acc_wr && avs_address == ibc_pkg::ADDR_CONTROL;
    assign wr_dat    = acc_wr && avs_address == ibc_pkg::ADDR_DATA;
    assign rd_dat    = acc_rd && avs_address == ibc_pkg::ADDR_DATA;
    // edges judged on the second and third stages only
    assign start_det = s.scl_s && s.scl_p && s.sda_p && !s.sda_s;
    assign stop_det  = s.scl_s && s.scl_p && !s.sda_p && s.sda_s;
    assign rise      = !s.scl_p && s.scl_s;
    assign fall      = s.scl_p && !s.scl_s;
    assign tdone     = s.timer >= HALF_CYCLES - 16'h0001;
    assign eng_tx    = s.tx && !s.slv_addr;

    always_comb begin
        logic arb_lose;
        logic [7:0] rd_mux;
        logic [7:0] byte_in;
        next_s   = s;
        arb_lose = 1'b0;
        byte_in  = {s.shift[6:0], s.sda_s};
        rd_mux   = 8'h00;
        case (avs_address)
            // repeated start bit always reads 0
            ibc_pkg::ADDR_CONTROL:  rd_mux = {s.ctl_en, s.ctl_ie, s.msel, s.tx, s.ack_drive_value, 3'h0};
            ibc_pkg::ADDR_STATUS:   rd_mux = {s.byte_done, s.addressed, s.busy, s.arbitration_lost_flag,
                                              1'b0, s.slave_direction_flag, s.pend, s.received_ack_flag};
            ibc_pkg::ADDR_DATA:     rd_mux = s.rx_data;
            ibc_pkg::ADDR_OWN:      rd_mux = {1'b0, s.own_addr};
            ibc_pkg::ADDR_CONTROL2: rd_mux = {s.gce, 7'h00};
            default:                rd_mux = 8'h00;
        endcase
        next_s.scl_m   = scl_i;
        next_s.scl_s   = s.scl_m;
        next_s.scl_p   = s.scl_s;
        next_s.sda_m   = sda_i;
        next_s.sda_s   = s.sda_m;
        next_s.sda_p   = s.sda_s;
        // one-cycle answer: stall the first cycle, release the second
        next_s.waitreq = !((avs_read || avs_write) && s.waitreq);
        if ((avs_read || avs_write) && s.waitreq) begin
            next_s.rdata = rd_mux;
        end
        next_s.timer = 16'(s.timer + 16'h0001);

        // software clears and configuration come first so hardware sets win
        if (wr_ctl) begin
            next_s.ctl_en    = wd[ibc_pkg::CTL_EN_BIT];
            next_s.ctl_ie    = wd[ibc_pkg::CTL_IE_BIT];
            next_s.tx        = wd[ibc_pkg::CTL_TX_BIT];
            next_s.ack_drive_value      = wd[ibc_pkg::CTL_ACK_DRIVE_VALUE_BIT];
            next_s.addressed = 1'b0;
        end
        if (acc_wr && avs_address == ibc_pkg::ADDR_STATUS) begin
            if (wd[ibc_pkg::ST_ARBITRATION_LOST_FLAG_BIT]) next_s.arbitration_lost_flag = 1'b0;
            if (wd[ibc_pkg::ST_IF_BIT]) next_s.pend = 1'b0;
        end
        if (acc_wr && avs_address == ibc_pkg::ADDR_OWN) next_s.own_addr = wd[6:0];
        if (acc_wr && avs_address == ibc_pkg::ADDR_CONTROL2) begin
            next_s.gce = wd[ibc_pkg::CTL2_GCE_BIT];
        end
        if ((rd_dat && !s.tx) || (wr_dat && s.tx)) next_s.byte_done = 1'b0;
        if (start_det) next_s.busy = 1'b1;
        if (stop_det) next_s.busy = 1'b0;

        case (s.state)
            ibc_pkg::ST_OFF: begin
                if (s.ctl_en) next_s.state = ibc_pkg::ST_IDLE;
            end
            ibc_pkg::ST_M_START: begin
                next_s.sda_drv = 1'b1;
                if (tdone) begin
                    next_s.scl_drv = 1'b1;
                    next_s.state   = ibc_pkg::ST_M_HOLD;
                end
            end
            ibc_pkg::ST_M_HOLD, ibc_pkg::ST_S_HOLD: begin
                next_s.scl_drv = 1'b1;
                next_s.timer   = 16'h0000;
                if (wr_dat && s.tx) begin
                    next_s.shift   = wd;
                    next_s.sda_drv = !wd[7];
                    next_s.bit_cnt = 4'h0;
                    next_s.state   = ibc_pkg::ST_XFER;
                end else if (rd_dat && !s.tx) begin
                    next_s.sda_drv = 1'b0;
                    next_s.bit_cnt = 4'h0;
                    next_s.state   = ibc_pkg::ST_XFER;
                end
                if (next_s.state == ibc_pkg::ST_XFER && s.state == ibc_pkg::ST_S_HOLD) begin
                    next_s.scl_drv = 1'b0;
                end
            end
            ibc_pkg::ST_XFER: begin
                if (s.msel) begin
                    if (s.scl_drv) begin
                        if (tdone) begin
                            next_s.scl_drv = 1'b0;
                            next_s.timer   = 16'h0000;
                        end
                    end else if (!s.scl_s) begin
                        // stretched by another device: keep the count at zero
                        next_s.timer = 16'h0000;
                    end else if (tdone) begin
                        next_s.scl_drv = 1'b1;
                        next_s.timer   = 16'h0000;
                    end
                end
                if (rise && s.bit_cnt < 4'h8) begin
                    if (s.msel && eng_tx && !s.sda_drv && !s.sda_s) begin
                        arb_lose = 1'b1;
                    end
                    next_s.shift   = byte_in;
                    next_s.bit_cnt = 4'(s.bit_cnt + 4'h1);
                    if (s.bit_cnt == 4'h7 && s.slv_addr) begin
                        if (s.shift[6:0] == s.own_addr ||
                            (s.shift[6:0] == ibc_pkg::GENERAL_CALL && s.gce)) begin
                            next_s.addressed = 1'b1;
                            next_s.slave_direction_flag       = s.sda_s;
                            next_s.pend      = 1'b1;
                        end else begin
                            next_s.slv_addr = 1'b0;
                            next_s.state    = ibc_pkg::ST_IDLE;
                        end
                    end else if (s.bit_cnt == 4'h7 && !eng_tx) begin
                        next_s.rx_data = byte_in;
                    end
                end else if (rise && s.bit_cnt == 4'h8) begin
                    // acknowledge seen after a transmitted byte
                    if (eng_tx) next_s.received_ack_flag = s.sda_s;
                    next_s.byte_done = 1'b1;
                    next_s.pend      = 1'b1;
                    next_s.bit_cnt   = 4'h9;
                end
                if (fall && s.bit_cnt >= 4'h1 && s.bit_cnt <= 4'h7 && eng_tx) begin
                    next_s.sda_drv = !s.shift[7];
                end else if (fall && s.bit_cnt == 4'h8) begin
                    next_s.sda_drv = eng_tx ? 1'b0 : (s.slv_addr || !s.ack_drive_value);
                end else if (fall && s.bit_cnt == 4'h9) begin
                    next_s.sda_drv  = 1'b0;
                    next_s.slv_addr = 1'b0;
                    next_s.scl_drv  = 1'b1;
                    if (s.msel) begin
                        next_s.state = ibc_pkg::ST_M_HOLD;
                    end else if (eng_tx && s.received_ack_flag) begin
                        // master ended the read: let go of the bus
                        next_s.scl_drv = 1'b0;
                        next_s.state   = ibc_pkg::ST_IDLE;
                    end else begin
                        next_s.state = ibc_pkg::ST_S_HOLD;
                    end
                end
            end
            ibc_pkg::ST_M_STOP, ibc_pkg::ST_M_RSTART: begin
                // stop: low, release clock, release data; restart adds a final low
                if (!s.scl_drv && !s.scl_s) next_s.timer = 16'h0000;
                if (tdone) begin
                    next_s.timer = 16'h0000;
                    next_s.step  = 2'(s.step + 2'h1);
                    case (s.step)
                        2'h0: next_s.scl_drv = 1'b0;
                        2'h1: next_s.sda_drv = s.state == ibc_pkg::ST_M_STOP;
                        2'h2: begin
                            if (s.state == ibc_pkg::ST_M_STOP) begin
                                next_s.sda_drv = 1'b0;
                                next_s.state   = ibc_pkg::ST_IDLE;
                            end else begin
                                next_s.scl_drv = 1'b1;
                                next_s.state   = ibc_pkg::ST_M_HOLD;
                            end
                        end
                        default: next_s.step = 2'h0;
                    endcase
                end
            end
            default: begin
                next_s.scl_drv = 1'b0;
                next_s.sda_drv = 1'b0;
            end
        endcase

        // a start seen by a non-master begins address reception
        if (start_det && !s.msel && s.ctl_en) begin
            next_s.state    = ibc_pkg::ST_XFER;
            next_s.slv_addr = 1'b1;
            next_s.bit_cnt  = 4'h0;
            next_s.scl_drv  = 1'b0;
            next_s.sda_drv  = 1'b0;
        end else if (stop_det && !s.msel && s.state != ibc_pkg::ST_OFF) begin
            next_s.state   = ibc_pkg::ST_IDLE;
            next_s.scl_drv = 1'b0;
            next_s.sda_drv = 1'b0;
        end

        if (wr_ctl && wd[ibc_pkg::CTL_EN_BIT]) begin
            if (wd[ibc_pkg::CTL_MST_BIT] && !s.msel) begin
                // start only on a free bus
                if (s.busy) begin
                    arb_lose = 1'b1;
                end else begin
                    // data falls together with the mode change
                    next_s.msel    = 1'b1;
                    next_s.state   = ibc_pkg::ST_M_START;
                    next_s.timer   = 16'h0000;
                    next_s.sda_drv = 1'b1;
                end
            end else if (!wd[ibc_pkg::CTL_MST_BIT] && s.msel) begin
                next_s.msel    = 1'b0;
                next_s.state   = ibc_pkg::ST_M_STOP;
                next_s.step    = 2'h0;
                next_s.timer   = 16'h0000;
                next_s.scl_drv = 1'b1;
                next_s.sda_drv = 1'b1;
            end else if (wd[ibc_pkg::CTL_REPEATED_START_REQUEST_BIT] && s.msel) begin
                // repeated start only from the held point
                if (s.state == ibc_pkg::ST_M_HOLD) begin
                    next_s.state   = ibc_pkg::ST_M_RSTART;
                    next_s.step    = 2'h0;
                    next_s.timer   = 16'h0000;
                    next_s.sda_drv = 1'b0;
                end else begin
                    arb_lose = 1'b1;
                end
            end
        end

        if (arb_lose) begin
            // drop the bus silently, no stop
            next_s.arbitration_lost_flag     = 1'b1;
            next_s.pend     = 1'b1;
            next_s.msel     = 1'b0;
            next_s.scl_drv  = 1'b0;
            next_s.sda_drv  = 1'b0;
            next_s.slv_addr = 1'b0;
            next_s.state    = ibc_pkg::ST_IDLE;
        end
        if (!s.ctl_en) begin
            next_s.state   = ibc_pkg::ST_OFF;
            next_s.msel    = 1'b0;
            next_s.busy    = 1'b0;
            next_s.scl_drv = 1'b0;
            next_s.sda_drv = 1'b0;
        end
        next_s.irq = next_s.pend && next_s.ctl_ie && next_s.ctl_en;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s          <= '0;
            s.waitreq  <= 1'b1;
            s.rx_data  <= ibc_pkg::DATA_RESET;
            s.own_addr <= ibc_pkg::OWN_RESET;
            s.scl_m    <= 1'b1;
            s.scl_s    <= 1'b1;
            s.scl_p    <= 1'b1;
            s.sda_m    <= 1'b1;
            s.sda_s    <= 1'b1;
            s.sda_p    <= 1'b1;
            s.state    <= ibc_pkg::ST_OFF;
        end else begin
            s <= next_s;
        end
    end

    assign avs_readdata    = {24'h000000, s.rdata};
    assign avs_waitrequest = s.waitreq;
    assign scl_o           = 1'b0;
    assign sda_o           = 1'b0;
    assign scl_oe          = s.scl_drv;
    assign sda_oe          = s.sda_drv;
    assign irq             = s.irq;

    AST_IRQ_BLOCKED: assert property (@(posedge core_clk) disable iff (!rst_b)
        !s.ctl_ie |-> !irq) else $error("interrupt raised while disabled");
    AST_IRQ_FOLLOWS: assert property (@(posedge core_clk) disable iff (!rst_b)
        (s.pend && s.ctl_ie && s.ctl_en) ##1 (s.pend && s.ctl_ie && s.ctl_en) |-> irq)
        else $error("interrupt missing while pending and enabled");
    AST_OFF_QUIET: assert property (@(posedge core_clk) disable iff (!rst_b)
        !s.ctl_en |=> !scl_oe && !sda_oe) else $error("disabled module drives bus");
    AST_START_SEQ: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wr_ctl && wd[7] && wd[5] && !s.msel && !s.busy && s.ctl_en)
        |=> (sda_oe && !scl_oe)[*2]) else $error("start not driven data first");
    AST_REPEATED_START_REQUEST_ZERO: assert property (@(posedge core_clk) disable iff (!rst_b)
        (avs_read && !s.waitreq && avs_address == ibc_pkg::ADDR_CONTROL)
        |-> !avs_readdata[2]) else $error("repeat start bit read back as 1");
    AST_BUSY_START: assert property (@(posedge core_clk) disable iff (!rst_b)
        (start_det && s.ctl_en) |=> s.busy) else $error("busy not set on start");
    AST_ARB_STICKY: assert property (@(posedge core_clk) disable iff (!rst_b)
        s.arbitration_lost_flag && !(acc_wr && avs_address == ibc_pkg::ADDR_STATUS && wd[4])
        |=> s.arbitration_lost_flag) else $error("arbitration flag lost without clear");
    AST_PEND_STICKY: assert property (@(posedge core_clk) disable iff (!rst_b)
        s.pend && !(acc_wr && avs_address == ibc_pkg::ADDR_STATUS && wd[1])
        |=> s.pend) else $error("pending flag lost without clear");
    AST_NO_RX_ON_TX: assert property (@(posedge core_clk) disable iff (!rst_b)
        (rd_dat && s.tx && s.state == ibc_pkg::ST_M_HOLD && !wr_ctl && !start_det)
        |=> s.state == ibc_pkg::ST_M_HOLD) else $error("read started a transfer in transmit");
    AST_MSB_FIRST: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wr_dat && s.tx && s.state == ibc_pkg::ST_M_HOLD && s.ctl_en && !start_det)
        |=> sda_oe == !$past(wd[7])) else $error("first bit is not the msb");

    COV_START: cover property (@(posedge core_clk) disable iff (!rst_b)
        s.state == ibc_pkg::ST_M_START ##1 s.state == ibc_pkg::ST_M_HOLD);
    COV_BYTE: cover property (@(posedge core_clk) disable iff (!rst_b)
        !s.byte_done ##1 s.byte_done);
    COV_ARB: cover property (@(posedge core_clk) disable iff (!rst_b) !s.arbitration_lost_flag ##1 s.arbitration_lost_flag);
    COV_ADDR: cover property (@(posedge core_clk) disable iff (!rst_b)
        !s.addressed ##1 s.addressed);
endmodule
`default_nettype wire

// ### include/ibc_pkg.sv
// constants, register map and states of the two-wire bus controller
package ibc_pkg;
    // register byte addresses
    localparam logic [4:0] ADDR_CONTROL  = 5'h00;
    localparam logic [4:0] ADDR_STATUS   = 5'h04;
    localparam logic [4:0] ADDR_DATA     = 5'h08;
    localparam logic [4:0] ADDR_OWN      = 5'h0c;
    localparam logic [4:0] ADDR_CONTROL2 = 5'h10;
    // bus_control fields
    localparam int CTL_EN_BIT   = 7;
    localparam int CTL_IE_BIT   = 6;
    localparam int CTL_MST_BIT  = 5;
    localparam int CTL_TX_BIT   = 4;
    localparam int CTL_ACK_DRIVE_VALUE_BIT = 3;
    localparam int CTL_REPEATED_START_REQUEST_BIT = 2;
    // bus_status fields
    localparam int ST_TCF_BIT   = 7;
    localparam int ST_SLAVE_ADDRESSED_FLAG_BIT  = 6;
    localparam int ST_BUSY_BIT  = 5;
    localparam int ST_ARBITRATION_LOST_FLAG_BIT  = 4;
    localparam int ST_SRW_BIT   = 2;
    localparam int ST_IF_BIT    = 1;
    localparam int ST_RECEIVED_ACK_FLAG_BIT  = 0;
    // control2 field
    localparam int CTL2_GCE_BIT = 7;
    // reset values and general call address
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET    = 8'h00;
    localparam logic [6:0] OWN_RESET     = 7'h00;
    localparam logic [6:0] GENERAL_CALL  = 7'h00;
    // bus clock timing
    localparam int CORE_CLK_HZ     = 20000000;
    localparam int SCL_RATE_HZ     = 100000;
    localparam int SCL_HALF_CYCLES = CORE_CLK_HZ / (2 * SCL_RATE_HZ);
    typedef enum logic [3:0] {
        ST_OFF, ST_IDLE, ST_M_START, ST_M_HOLD, ST_XFER,
        ST_S_HOLD, ST_M_STOP, ST_M_RSTART
    } ibc_state_e;
endpackage

// ### bench/ibc_slave_model.sv
// behavioural far-side slave: captures one byte after a start, optional ack
`timescale 1ns/1ps
`default_nettype none
module ibc_slave_model (
    input  wire logic       scl,      // bus clock level
    input  wire logic       sda,      // bus data level
    input  wire logic       ack_en,   // acknowledge the byte
    output logic            pull_low, // pulls data line low
    output logic [7:0]      rx_byte   // byte seen after start
);
    logic [3:0] bits = 4'ha;
    initial pull_low = 1'b0;
    initial rx_byte = 8'h00;
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            bits = 4'h0;
        end
    end
    always @(posedge scl) begin
        if (bits < 4'h8) begin
            rx_byte = {rx_byte[6:0], sda};
        end
        if (bits < 4'ha) begin
            bits = bits + 4'h1;
        end
    end
    // released line floats to the pull-up level
    always @(negedge scl) begin
        pull_low = ack_en && (bits == 4'h8);
    end
endmodule
`default_nettype wire

// ### bench/ibc_ctrl_bench.sv
// self-checking bench for the two-wire bus controller registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module ibc_ctrl_bench;
    typedef struct { logic [4:0] a; logic [7:0] d; logic [7:0] e; } ibc_row_s;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic        ack_en = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0]  avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, scl_o, scl_oe, sda_o, sda_oe, irq, pull_low;
    logic [7:0]  rx_byte, q;
    int          bad_count = 0;
    int          n_compared = 0;
    wire logic   scl = ~scl_oe;
    wire logic   sda = ~(sda_oe | pull_low);
    ibc_row_s rows [4] = '{'{5'h00, 8'hcc, 8'hc8}, '{5'h00, 8'h00, 8'h00},
                           '{5'h14, 8'hff, 8'h00}, '{5'h04, 8'h12, 8'h00}};
    always #25 core_clk = ~core_clk;
    ibc_ctrl #(.HALF_CYCLES(16'h0008)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_i(scl),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
    ibc_slave_model i_peer (.scl(scl), .sda(sda), .ack_en(ack_en), .pull_low(pull_low),
        .rx_byte(rx_byte));
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_read <= ~wr;
        avs_write <= wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // polls status; bounded so a stuck flag shows as a mismatch
    task automatic wait_status(input int b, input logic v);
        int n = 0;
        do begin
            bus(1'b0, ibc_pkg::ADDR_STATUS, 8'h00);
            n++;
        end while (q[b] !== v && n < 400);
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        bus(1'b0, ibc_pkg::ADDR_STATUS, 8'h00);
        `CHK("status at reset", 8'h00, q)
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 8'h00);
            `CHK("register readback", rows[i].e, q)
        end
        // direction set before any data access
        bus(1'b1, ibc_pkg::ADDR_CONTROL, 8'h90);
        bus(1'b1, ibc_pkg::ADDR_CONTROL, 8'hb0);
        wait_status(ibc_pkg::ST_BUSY_BIT, 1'b1);
        `CHK("busy after start", 1'b1, q[5])
        // data is taken only once the start hold has run out
        repeat (16) @(posedge core_clk);
        bus(1'b1, ibc_pkg::ADDR_DATA, 8'ha4);
        wait_status(ibc_pkg::ST_TCF_BIT, 1'b1);
        `CHK("status after acked byte", 8'ha2, q)
        `CHK("address byte on wire", 8'ha4, rx_byte)
        `CHK("irq while masked", 1'b0, irq)
        bus(1'b0, ibc_pkg::ADDR_DATA, 8'h00);
        `CHK("data read in transmit", 8'h00, q)
        bus(1'b1, ibc_pkg::ADDR_STATUS, 8'h02);
        bus(1'b0, ibc_pkg::ADDR_STATUS, 8'h00);
        `CHK("pending after clear", 1'b0, q[1])
        `CHK("done kept by read in transmit", 1'b1, q[7])
        bus(1'b1, ibc_pkg::ADDR_CONTROL, 8'h90);
        wait_status(ibc_pkg::ST_BUSY_BIT, 1'b0);
        `CHK("busy after stop", 1'b0, q[5])
        ack_en <= 1'b0;
        bus(1'b1, ibc_pkg::ADDR_CONTROL, 8'hf0);
        wait_status(ibc_pkg::ST_BUSY_BIT, 1'b1);
        repeat (16) @(posedge core_clk);
        bus(1'b1, ibc_pkg::ADDR_DATA, 8'h5b);
        wait_status(ibc_pkg::ST_TCF_BIT, 1'b1);
        `CHK("status after refused byte", 8'ha3, q)
        `CHK("irq while enabled", 1'b1, irq)
        `CHK("second byte on wire", 8'h5b, rx_byte)
        // repeat start while a byte is in flight is refused
        bus(1'b1, ibc_pkg::ADDR_DATA, 8'hff);
        bus(1'b1, ibc_pkg::ADDR_CONTROL, 8'hf4);
        bus(1'b0, ibc_pkg::ADDR_STATUS, 8'h00);
        `CHK("status after lost arbitration", 8'h33, q)
        `CHK("lines after lost arbitration", 2'b00, {scl_oe, sda_oe})
        bus(1'b1, ibc_pkg::ADDR_STATUS, 8'h10);
        bus(1'b0, ibc_pkg::ADDR_STATUS, 8'h00);
        `CHK("status after arbitration clear", 8'h23, q)
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        bus(1'b0, ibc_pkg::ADDR_CONTROL, 8'h00);
        `CHK("control after second reset", 8'h00, q)
        `CHK("outputs after second reset", 4'h0, {scl_oe, sda_oe, scl_o, sda_o})
        bus(1'b0, ibc_pkg::ADDR_STATUS, 8'h00);
        `CHK("status after second reset", 8'h00, q)
        `CHK("irq after second reset", 1'b0, irq)
        report_and_stop;
    end
    // two transfers need some hundreds of cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        report_and_stop;
    end
endmodule
`default_nettype wire
